// file: design/pcat_pkg.sv
`default_nettype none
package pcat_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] AREA5_CARD_BUS_TIMING_OFS = 12'h000;
   localparam logic [11:0] AREA6_CARD_BUS_TIMING_OFS = 12'h004;
   localparam logic [31:0] CFG_RESET = 32'h0000_0500;
   localparam logic [31:0] CFG_WRITE_MASK = 32'h0030_7fcf;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ADDR_HOLD_LSB = 0;
   localparam int EXT_WAIT_MASK_BIT = 6;
   localparam int WAIT_COUNT_LSB = 7;
   localparam int STROBE_DELAY_LSB = 11;
   localparam int LOWER_SPACE_IO_BIT = 20;
   localparam int UPPER_SPACE_IO_BIT = 21;
   localparam int FIELD_W = 4;

   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int CNT_W = 7;
   localparam int CARD_ADDR_W = 26;
   localparam int CARD_DATA_W = 16;
   localparam int TOP_ADDRESS_BIT = 25;
   localparam int CLK_PERIOD_NS = 100;
   localparam logic [3:0] STROBE_DELAY_MAX_CODE = 4'h7;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;

   typedef enum logic [1:0] {
      PCAT_IDLE,
      PCAT_SETUP,
      PCAT_STROBE,
      PCAT_HOLD
   } pcat_state_type;

   // access wait cycles per code
   function automatic logic [CNT_W-1:0] pcat_wait_cycles(input logic [3:0] code);
      logic [CNT_W-1:0] n;
      n = 7'h03;
      unique case (code)
         4'h0: n = 7'h03;
         4'h1: n = 7'h06;
         4'h2: n = 7'h09;
         4'h3: n = 7'h0c;
         4'h4: n = 7'h0f;
         4'h5: n = 7'h12;
         4'h6: n = 7'h16;
         4'h7: n = 7'h1a;
         4'h8: n = 7'h1e;
         4'h9: n = 7'h21;
         4'ha: n = 7'h24;
         4'hb: n = 7'h26;
         4'hc: n = 7'h34;
         4'hd: n = 7'h3c;
         4'he: n = 7'h40;
         4'hf: n = 7'h50;
      endcase
      return n;
   endfunction : pcat_wait_cycles

   // io card select from top address bit
   function automatic logic pcat_io_space(input logic [31:0] cfg, input logic top);
      return top ? cfg[UPPER_SPACE_IO_BIT] : cfg[LOWER_SPACE_IO_BIT];
   endfunction : pcat_io_space
endpackage : pcat_pkg
`default_nettype wire

// file: design/pcat_timing.sv
`default_nettype none
module pcat_timing (
   input wire logic [31:0] cfg,
   output logic [6:0] delay_last,
   output logic [6:0] wait_last,
   output logic [6:0] hold_last,
   output logic ext_wait_mask
);
   logic [3:0] delay_code;
   logic [3:0] wait_code;
   logic [3:0] hold_code;

   // ----------------------------------------------------------------
   // field decode, last-cycle indices
   // ----------------------------------------------------------------
   always_comb begin
      delay_code = cfg[pcat_pkg::STROBE_DELAY_LSB +: pcat_pkg::FIELD_W];
      wait_code = cfg[pcat_pkg::WAIT_COUNT_LSB +: pcat_pkg::FIELD_W];
      hold_code = cfg[pcat_pkg::ADDR_HOLD_LSB +: pcat_pkg::FIELD_W];
      // RULE8: half cycle rounded up
      if (delay_code > pcat_pkg::STROBE_DELAY_MAX_CODE) begin
         delay_last = {3'h0, pcat_pkg::STROBE_DELAY_MAX_CODE};
      end else begin
         delay_last = {3'h0, delay_code};
      end
      // RULE1: wait table lookup
      wait_last = pcat_pkg::pcat_wait_cycles(wait_code) - 7'h01;
      // RULE6: hold half cycle rounded up
      hold_last = {3'h0, hold_code};
      // RULE3: mask bit decode
      ext_wait_mask = cfg[pcat_pkg::EXT_WAIT_MASK_BIT];
   end
endmodule : pcat_timing
`default_nettype wire

// file: design/pcat_card_ctrl.sv
// Overview of operation
// RULE1: sixteen codes select 3 to 80 wait cycles
// RULE2: wait field resets 1010, others zero
// RULE3: mask clear honours wait, set ignores it
// RULE4: mask applies even with zero wait cycles
// RULE5: bits 5 and 4 read zero
// RULE6: address held n plus half cycles
// RULE7: hold 3:0, mask 6, wait 10:7
// RULE8: strobe delayed n plus half; 1xxx prohibited
// RULE9: bits 21/20 pick io card by top bit
// RULE10: asserted wait extends access until released
`default_nettype none
module pcat_card_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic req_area6,
   input wire logic req_write,
   input wire logic [25:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic req_busy,
   output logic req_done,
   output logic [15:0] req_rdata,
   output logic [25:0] card_addr,
   output logic card_cs5_n,
   output logic card_cs6_n,
   output logic card_rd_n,
   output logic card_we_n,
   output logic [15:0] card_wdata,
   output logic card_wdata_oe,
   output logic card_io_space,
   input wire logic [15:0] card_rdata,
   input wire logic card_wait_n
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      pcat_pkg::pcat_state_type state;
      logic [31:0] area5;
      logic [31:0] area6;
      logic [6:0] cnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic area6_sel;
      logic write;
      logic [25:0] addr;
      logic [15:0] wdata;
      logic wdata_oe;
      logic cs5_n;
      logic cs6_n;
      logic rd_n;
      logic we_n;
      logic io_space;
      logic busy;
      logic done;
      logic [15:0] rdata;
   } pcat_regs_type;

   pcat_regs_type st_r;
   pcat_regs_type st_nxt;
   logic [31:0] cfg_cur;
   logic [6:0] delay_last;
   logic [6:0] wait_last;
   logic [6:0] hold_last;
   logic ext_mask;
   logic apb_wr;
   logic strobe_n;
   logic cs_n;

   // reserved bits read as zero
   function automatic logic [31:0] cfg_read(input logic [31:0] word);
      return word & pcat_pkg::CFG_WRITE_MASK;
   endfunction : cfg_read

   // prohibited strobe delay codes refused
   function automatic logic cfg_legal(input logic [31:0] word);
      return !word[pcat_pkg::STROBE_DELAY_LSB + 3];
   endfunction : cfg_legal

   assign cfg_cur = st_r.area6_sel ? st_r.area6 : st_r.area5;
   assign apb_wr = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
   assign strobe_n = st_r.rd_n && st_r.we_n;
   assign cs_n = st_r.cs5_n && st_r.cs6_n;

   pcat_timing u_timing (
      .cfg(cfg_cur),
      .delay_last(delay_last),
      .wait_last(wait_last),
      .hold_last(hold_last),
      .ext_wait_mask(ext_mask)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.done = 1'b0;
      // apb setup phase: decode, answer next cycle
      if (psel && !penable && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.prdata = 32'h0000_0000;
         if (paddr == pcat_pkg::AREA5_CARD_BUS_TIMING_OFS) begin
            // RULE5: reserved read zero
            st_nxt.prdata = cfg_read(st_r.area5);
            st_nxt.pslverr = pwrite && !cfg_legal(pwdata);
         end else if (paddr == pcat_pkg::AREA6_CARD_BUS_TIMING_OFS) begin
            st_nxt.prdata = cfg_read(st_r.area6);
            // RULE8: prohibited code refused
            st_nxt.pslverr = pwrite && !cfg_legal(pwdata);
         end else begin
            st_nxt.pslverr = 1'b1;
         end
      end else if (psel && penable && st_r.pready) begin
         st_nxt.prdata = 32'h0000_0000;
      end
      // RULE7: field placement on write
      if (apb_wr && paddr == pcat_pkg::AREA5_CARD_BUS_TIMING_OFS) begin
         st_nxt.area5 = pwdata & pcat_pkg::CFG_WRITE_MASK;
      end
      if (apb_wr && paddr == pcat_pkg::AREA6_CARD_BUS_TIMING_OFS) begin
         st_nxt.area6 = pwdata & pcat_pkg::CFG_WRITE_MASK;
      end
      // card access sequencer
      unique case (st_r.state)
         pcat_pkg::PCAT_IDLE: begin
            if (req_valid) begin
               st_nxt.state = pcat_pkg::PCAT_SETUP;
               st_nxt.cnt = 7'h00;
               st_nxt.area6_sel = req_area6;
               st_nxt.write = req_write;
               st_nxt.addr = req_addr;
               st_nxt.wdata = req_wdata;
               st_nxt.wdata_oe = req_write;
               st_nxt.cs5_n = req_area6;
               st_nxt.cs6_n = !req_area6;
               st_nxt.busy = 1'b1;
               // RULE9: io or memory card
               st_nxt.io_space = pcat_pkg::pcat_io_space(req_area6 ? st_r.area6 : st_r.area5,
                                                         req_addr[pcat_pkg::TOP_ADDRESS_BIT]);
            end
         end
         pcat_pkg::PCAT_SETUP: begin
            // RULE8: address to strobe delay
            if (st_r.cnt >= delay_last) begin
               st_nxt.state = pcat_pkg::PCAT_STROBE;
               st_nxt.cnt = 7'h00;
               st_nxt.rd_n = st_r.write;
               st_nxt.we_n = !st_r.write;
            end else begin
               st_nxt.cnt = st_r.cnt + 7'h01;
            end
         end
         pcat_pkg::PCAT_STROBE: begin
            // RULE1: programmed wait cycles
            // RULE3: external wait gated by mask
            // RULE4: mask honoured for any count
            // RULE10: wait extends strobe
            if (st_r.cnt >= wait_last && (ext_mask || card_wait_n)) begin
               st_nxt.state = pcat_pkg::PCAT_HOLD;
               st_nxt.cnt = 7'h00;
               st_nxt.rd_n = 1'b1;
               st_nxt.we_n = 1'b1;
               if (!st_r.write) begin
                  st_nxt.rdata = card_rdata;
               end
            end else if (st_r.cnt != pcat_pkg::CNT_MAX) begin
               st_nxt.cnt = st_r.cnt + 7'h01;
            end
         end
         pcat_pkg::PCAT_HOLD: begin
            // RULE6: address hold after strobe
            if (st_r.cnt >= hold_last) begin
               st_nxt.state = pcat_pkg::PCAT_IDLE;
               st_nxt.cnt = 7'h00;
               st_nxt.cs5_n = 1'b1;
               st_nxt.cs6_n = 1'b1;
               st_nxt.wdata_oe = 1'b0;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt + 7'h01;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.state <= pcat_pkg::PCAT_IDLE;
         // RULE2: reset values
         st_r.area5 <= pcat_pkg::CFG_RESET;
         st_r.area6 <= pcat_pkg::CFG_RESET;
         st_r.cs5_n <= 1'b1;
         st_r.cs6_n <= 1'b1;
         st_r.rd_n <= 1'b1;
         st_r.we_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign req_busy = st_r.busy;
   assign req_done = st_r.done;
   assign req_rdata = st_r.rdata;
   assign card_addr = st_r.addr;
   assign card_cs5_n = st_r.cs5_n;
   assign card_cs6_n = st_r.cs6_n;
   assign card_rd_n = st_r.rd_n;
   assign card_we_n = st_r.we_n;
   assign card_wdata = st_r.wdata;
   assign card_wdata_oe = st_r.wdata_oe;
   assign card_io_space = st_r.io_space;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_reset_values;
      !$past(presetn) |-> st_r.area5 == pcat_pkg::CFG_RESET && st_r.area6 == pcat_pkg::CFG_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) // RULE2
      else $error("config register reset value wrong");

   property p_wait_min;
      $fell(strobe_n) |-> (!strobe_n)[*3];
   endproperty
   a_wait_min: assert property (p_wait_min) // RULE1
      else $error("strobe shorter than three cycles");

   property p_wait_count;
      $rose(strobe_n) |-> $past(st_r.cnt) >= $past(wait_last);
   endproperty
   a_wait_count: assert property (p_wait_count) // RULE1
      else $error("strobe ended before wait count");

   property p_mask_ignores;
      st_r.state == pcat_pkg::PCAT_STROBE && ext_mask && st_r.cnt >= wait_last
         |=> st_r.state == pcat_pkg::PCAT_HOLD && strobe_n;
   endproperty
   a_mask_ignores: assert property (p_mask_ignores) // RULE3 RULE4
      else $error("masked wait still extended access");

   property p_wait_extends;
      st_r.state == pcat_pkg::PCAT_STROBE && !ext_mask && !card_wait_n
         |=> st_r.state == pcat_pkg::PCAT_STROBE && !strobe_n;
   endproperty
   a_wait_extends: assert property (p_wait_extends) // RULE10
      else $error("honoured wait did not extend strobe");

   property p_reserved_zero;
      st_r.pready |-> st_r.prdata[5:4] == 2'h0 && st_r.prdata[31:22] == 10'h000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // RULE5
      else $error("reserved bits read nonzero");

   property p_addr_hold;
      st_r.state == pcat_pkg::PCAT_HOLD && st_r.cnt < hold_last
         |=> st_r.state == pcat_pkg::PCAT_HOLD && $stable(st_r.addr) && strobe_n && !cs_n;
   endproperty
   a_addr_hold: assert property (p_addr_hold) // RULE6
      else $error("address hold cut short");

   property p_strobe_delay;
      $fell(cs_n) |-> strobe_n ##1 (strobe_n || delay_last == 7'h00);
   endproperty
   a_strobe_delay: assert property (p_strobe_delay) // RULE8
      else $error("strobe asserted without delay");

   property p_io_space;
      st_r.state == pcat_pkg::PCAT_SETUP
         |-> st_r.io_space == pcat_pkg::pcat_io_space(cfg_cur, st_r.addr[25]);
   endproperty
   a_io_space: assert property (p_io_space) // RULE9
      else $error("io space select wrong");

   property p_field_write;
      apb_wr && paddr == pcat_pkg::AREA5_CARD_BUS_TIMING_OFS
         |=> st_r.area5 == ($past(pwdata) & pcat_pkg::CFG_WRITE_MASK);
   endproperty
   a_field_write: assert property (p_field_write) // RULE7
      else $error("register write not stored");

   c_apb_read: cover property (psel && penable && st_r.pready && !pwrite);
   c_apb_write: cover property (apb_wr);
   c_wait_extend: cover property (st_r.state == pcat_pkg::PCAT_STROBE && !card_wait_n ##2 $rose(strobe_n));
   c_io_done: cover property (st_r.io_space && st_r.done);
endmodule : pcat_card_ctrl
`default_nettype wire

// file: bench/pcat_card_model.sv
`default_nettype none
module pcat_card_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [25:0] card_addr,
   input wire logic card_cs5_n,
   input wire logic card_cs6_n,
   input wire logic card_rd_n,
   input wire logic card_we_n,
   input wire logic [15:0] card_wdata,
   input wire logic card_wdata_oe,
   input wire logic [7:0] stall_len,
   output logic [15:0] card_rdata,
   output logic card_wait_n
);
   // ----------------------------------------------------------------
   // card storage and wait
   // ----------------------------------------------------------------
   logic [15:0] mem_r [16];
   logic [15:0] last_r;
   logic [7:0] stall_cnt_r;
   logic sel;
   logic strobe;
   logic rd_act;
   assign sel = ~(card_cs5_n & card_cs6_n);
   assign strobe = sel & ~(card_rd_n & card_we_n);
   assign rd_act = sel & ~card_rd_n;
   // wait held for stall_len strobe cycles
   assign card_wait_n = ~(strobe && (stall_cnt_r < stall_len));
   // released bus shows inverse of last value
   assign card_rdata = rd_act ? mem_r[card_addr[3:0]] : ~last_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_cnt_r <= 8'h00;
         last_r <= 16'h0000;
      end else begin
         stall_cnt_r <= strobe ? stall_cnt_r + 8'h01 : 8'h00;
         if (rd_act) begin
            last_r <= card_rdata;
         end
         if (sel && !card_we_n && card_wdata_oe) begin
            mem_r[card_addr[3:0]] <= card_wdata;
         end
      end
   end
endmodule : pcat_card_model
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic req_valid, req_area6, req_write, req_busy, req_done, rerr, io_seen;
   logic [25:0] req_addr, card_addr;
   logic [15:0] req_wdata, req_rdata, card_wdata, card_rdata, rd_seen;
   logic card_cs5_n, card_cs6_n, card_rd_n, card_we_n, card_wdata_oe;
   logic card_io_space, card_wait_n;
   logic [7:0] stall_len;
   int err_count, total_checks, n_setup, n_strobe, n_hold;
   int wc_tab[16] = '{3, 6, 9, 12, 15, 18, 22, 26, 30, 33, 36, 38, 52, 60, 64, 80};
   pcat_card_ctrl i_pcat_card_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_area6(req_area6),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_busy(req_busy), .req_done(req_done), .req_rdata(req_rdata),
      .card_addr(card_addr), .card_cs5_n(card_cs5_n), .card_cs6_n(card_cs6_n),
      .card_rd_n(card_rd_n), .card_we_n(card_we_n), .card_wdata(card_wdata),
      .card_wdata_oe(card_wdata_oe), .card_io_space(card_io_space),
      .card_rdata(card_rdata), .card_wait_n(card_wait_n));
   pcat_card_model i_pcat_card_model (.pclk(pclk), .presetn(presetn),
      .card_addr(card_addr), .card_cs5_n(card_cs5_n), .card_cs6_n(card_cs6_n),
      .card_rd_n(card_rd_n), .card_we_n(card_we_n), .card_wdata(card_wdata),
      .card_wdata_oe(card_wdata_oe), .stall_len(stall_len), .card_rdata(card_rdata),
      .card_wait_n(card_wait_n));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   function automatic logic [11:0] ofs(input logic a6);
      return a6 ? pcat_pkg::AREA6_CARD_BUS_TIMING_OFS : pcat_pkg::AREA5_CARD_BUS_TIMING_OFS;
   endfunction : ofs
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic access(input logic a6, input logic wr, input logic [25:0] a,
                         input logic [15:0] d);
      logic cs, stb, seen, busy_ok;
      n_setup = 0;
      n_strobe = 0;
      n_hold = 0;
      seen = 1'b0;
      busy_ok = 1'b1;
      req_valid <= 1'b1;
      req_area6 <= a6;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      @(posedge pclk);
      req_valid <= 1'b0;
      forever begin
         @(negedge pclk);
         if (req_done === 1'b1) break;
         cs = a6 ? card_cs6_n : card_cs5_n;
         stb = wr ? card_we_n : card_rd_n;
         if (cs === 1'b0 && req_busy !== 1'b1) begin
            busy_ok = 1'b0;
         end
         if (cs === 1'b0 && stb === 1'b0) begin
            n_strobe++;
            seen = 1'b1;
            io_seen = card_io_space;
         end else if (cs === 1'b0 && seen) begin
            n_hold++;
         end else if (cs === 1'b0) begin
            n_setup++;
         end
      end
      rd_seen = req_rdata;
      chk({31'h0, busy_ok}, 32'h1);
      chk({31'h0, req_busy}, 32'h0);
      @(posedge pclk);
   endtask : access
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      apb(1'b0, ofs(1'b0), 32'h0);
      chk(rdat, 32'h00000500);
      apb(1'b0, ofs(1'b1), 32'h0);
      chk(rdat, 32'h00000500);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, ofs(1'b0), 32'h00303fcf);
      chk({31'h0, rerr}, 32'h0);
      apb(1'b0, ofs(1'b0), 32'h0);
      chk(rdat, 32'h00303fcf);
      apb(1'b1, ofs(1'b0), 32'h00004000);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b0, ofs(1'b0), 32'h0);
      chk(rdat, 32'h00303fcf);
   endtask : t_regs
   task automatic t_waits;
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, ofs(1'b0), (32'(c) << 7) | 32'h40);
         access(1'b0, 1'b0, 26'h0000003, 16'h0);
         chk(32'(n_strobe), 32'(wc_tab[c]));
         chk(32'(n_setup + n_hold), 32'h2);
      end
   endtask : t_waits
   task automatic t_ext_wait;
      stall_len <= 8'h0a;
      apb(1'b1, ofs(1'b0), 32'h0);
      access(1'b0, 1'b0, 26'h0000003, 16'h0);
      chk(32'(n_strobe), 32'd11);
      apb(1'b1, ofs(1'b0), 32'h40);
      access(1'b0, 1'b0, 26'h0000003, 16'h0);
      chk(32'(n_strobe), 32'd3);
      stall_len <= 8'h00;
   endtask : t_ext_wait
   task automatic t_timing;
      apb(1'b1, ofs(1'b1), 32'h0020384f);
      access(1'b1, 1'b1, 26'h2000005, 16'ha5c3);
      chk(32'(n_setup), 32'd8);
      chk(32'(n_hold), 32'd16);
      chk({31'h0, io_seen}, 32'h1);
      access(1'b1, 1'b0, 26'h0000005, 16'h0);
      chk({31'h0, io_seen}, 32'h0);
      chk({16'h0, rd_seen}, 32'h0000a5c3);
   endtask : t_timing
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, req_valid, req_area6, req_write} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      req_addr = 26'h0;
      req_wdata = 16'h0;
      stall_len = 8'h00;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_waits();
      t_ext_wait();
      t_timing();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
